/* design/ocfd_pkg.sv */
// constants, field layouts and carrier types for the configuration fuse decoder
package ocfd_pkg;

	// ----------------------------------------------------------------
	// fuse array geometry and register indices
	// ----------------------------------------------------------------
	localparam int NUM_WORDS = 7;
	localparam int WORD_W = 16;
	localparam int ADDR_W = 4;
	localparam logic [3:0] ADDR_OSC_WORD = 4'h0;
	localparam logic [3:0] ADDR_WDT_WORD = 4'h1;
	localparam logic [3:0] ADDR_PROT_WORD = 4'h6;
	localparam logic [3:0] ADDR_ERASE = 4'h7;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_ACTIVE = 4'h9;
	localparam logic [15:0] FUSE_ERASED = 16'hFFFF;
	localparam logic [15:0] READ_UNMAPPED = 16'h0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CSM_LSB = 14;
	localparam int SRC_LSB = 8;
	localparam int PRI_LSB = 0;
	localparam int WDT_EN_BIT = 15;
	localparam int PROT_BIT = 0;
	localparam int ERASE_GO_BIT = 15;
	localparam int ERASE_IDX_LSB = 0;

	// ----------------------------------------------------------------
	// startup source, pll factor and oscillator family codes
	// ----------------------------------------------------------------
	localparam logic [1:0] SRC_LP_32K = 2'h0;
	localparam logic [1:0] SRC_FAST_RC = 2'h1;
	localparam logic [1:0] SRC_LP_RC = 2'h2;
	localparam logic [1:0] SRC_PRIMARY = 2'h3;
	localparam logic [1:0] PLL_NONE = 2'h0;
	localparam logic [1:0] PLL_X4 = 2'h1;
	localparam logic [1:0] PLL_X8 = 2'h2;
	localparam logic [1:0] PLL_X16 = 2'h3;
	localparam logic [2:0] FAM_EXT_CLK = 3'h0;
	localparam logic [2:0] FAM_EXT_RC = 3'h1;
	localparam logic [2:0] FAM_STD_XTAL = 3'h2;
	localparam logic [2:0] FAM_HS_XTAL = 3'h3;
	localparam logic [2:0] FAM_RESERVED = 3'h4;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic clk_switch_en;
		logic fail_safe_en;
		logic [1:0] startup_src;
		logic [3:0] prim_mode;
		logic [2:0] family;
		logic [1:0] pll_mult;
		logic osc_pin_clkout;
		logic mode_reserved;
		logic wdt_en;
		logic code_protect;
	} ocfd_settings_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} ocfd_bus_req_t;

	typedef struct packed {
		logic rd_req;
		logic wr_req;
	} ocfd_pm_req_t;

	// safe settings shown until the first capture after reset
	localparam ocfd_settings_t SETTINGS_RESET = '{
		clk_switch_en: 1'b0, fail_safe_en: 1'b0, startup_src: SRC_FAST_RC,
		prim_mode: 4'hC, family: FAM_EXT_CLK, pll_mult: PLL_NONE,
		osc_pin_clkout: 1'b0, mode_reserved: 1'b0, wdt_en: 1'b0,
		code_protect: 1'b1};

endpackage : ocfd_pkg

/* design/ocfd_top.sv */
// configuration fuse store and power-on oscillator setting decoder
//
// Notes on behaviour
// [RULE1] seven sixteen-bit fuse words, bitwise settable
// [RULE2] system bits set power-on oscillator, watchdog
// [RULE3] code protect blocks program memory read/write
// [RULE4] programmer rewrites every word it erases
// [RULE5] programmer uses matching oscillator word layout
// [RULE6] switch/monitor field: 1x off, 01, 00
// [RULE7] startup source: primary, lp rc, fast rc, 32k
// [RULE8] 1111 ext x16, 1101 ext x4, pin free
// [RULE9] 1100 ext no pll; 1011 ext clock out
// [RULE10] programmer never writes reserved code 1010
// [RULE11] 1001 rc clock out; 1000 rc pin free
// [RULE12] 0111..0100 std crystal x16 x8 x4 none
// [RULE13] 001x selects high speed crystal
// [RULE14] 1110 external clock x8, pin free
// [RULE15] settings captured after reset, held until reset
`timescale 1ns/100ps
`default_nettype none

module ocfd_top (
	input wire logic ref_clk, // 40 MHz system clock
	input wire logic reset, // async reset, active high
	input wire ocfd_pkg::ocfd_bus_req_t bus_req, // register port request
	output logic [15:0] bus_rdata, // read data, cycle after read
	input wire ocfd_pkg::ocfd_pm_req_t pm_req, // program memory access
	output logic pm_rd_grant, // program memory read allowed
	output logic pm_wr_grant, // program memory write allowed
	output ocfd_pkg::ocfd_settings_t settings, // active power-on settings
	output logic settings_valid // settings captured since reset
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		ocfd_pkg::ocfd_settings_t act;
		logic captured;
		logic [6:0] erase_pend;
		logic [15:0] rdata;
	} ocfd_state_t;

	ocfd_state_t st_r;
	ocfd_state_t st_nxt;
	ocfd_pkg::ocfd_settings_t dec;
	logic [15:0] osc_w;
	logic [1:0] csm;
	logic [3:0] primary_osc_mode;
	logic [2:0] erase_idx;
	logic word_hit;

	// non-volatile words survive reset; blank parts read as erased
	logic [15:0] fuse_mem [ocfd_pkg::NUM_WORDS] =
		'{default: ocfd_pkg::FUSE_ERASED};

	// ----------------------------------------------------------------
	// fuse storage
	// ----------------------------------------------------------------
	assign word_hit = bus_req.addr <= ocfd_pkg::ADDR_PROT_WORD;
	assign erase_idx = bus_req.wdata[ocfd_pkg::ERASE_IDX_LSB +: 3];

	// program or erase a word; an erased word holds all ones
	always_ff @(posedge ref_clk) begin
		if (bus_req.wr && word_hit) begin
			fuse_mem[bus_req.addr[2:0]] <= bus_req.wdata; // see [RULE1]
		end else if (bus_req.wr && bus_req.addr == ocfd_pkg::ADDR_ERASE
				&& bus_req.wdata[ocfd_pkg::ERASE_GO_BIT]
				&& erase_idx < 3'(ocfd_pkg::NUM_WORDS)) begin
			fuse_mem[erase_idx] <= ocfd_pkg::FUSE_ERASED;
		end
	end

	// ----------------------------------------------------------------
	// decode of the stored words
	// ----------------------------------------------------------------
	assign osc_w = fuse_mem[ocfd_pkg::ADDR_OSC_WORD[2:0]];
	assign csm = osc_w[ocfd_pkg::CSM_LSB +: 2];
	assign primary_osc_mode = osc_w[ocfd_pkg::PRI_LSB +: 4];

	// field decode, evaluated on the stored image
	always_comb begin
		dec = ocfd_pkg::SETTINGS_RESET;
		dec.clk_switch_en = ~csm[1]; // see [RULE6]
		dec.fail_safe_en = ~csm[1] & ~csm[0]; // see [RULE6]
		dec.startup_src = osc_w[ocfd_pkg::SRC_LSB +: 2]; // see [RULE7]
		dec.prim_mode = primary_osc_mode;
		dec.osc_pin_clkout = 1'b0;
		dec.mode_reserved = 1'b0;
		dec.pll_mult = ocfd_pkg::PLL_NONE;
		case (primary_osc_mode)
			4'hF: begin
				dec.family = ocfd_pkg::FAM_EXT_CLK; // see [RULE8]
				dec.pll_mult = ocfd_pkg::PLL_X16;
			end
			4'hE: begin
				dec.family = ocfd_pkg::FAM_EXT_CLK; // see [RULE14]
				dec.pll_mult = ocfd_pkg::PLL_X8;
			end
			4'hD: begin
				dec.family = ocfd_pkg::FAM_EXT_CLK; // see [RULE8]
				dec.pll_mult = ocfd_pkg::PLL_X4;
			end
			4'hC: begin
				dec.family = ocfd_pkg::FAM_EXT_CLK; // see [RULE9]
			end
			4'hB: begin
				dec.family = ocfd_pkg::FAM_EXT_CLK; // see [RULE9]
				dec.osc_pin_clkout = 1'b1;
			end
			4'h9: begin
				dec.family = ocfd_pkg::FAM_EXT_RC; // see [RULE11]
				dec.osc_pin_clkout = 1'b1;
			end
			4'h8: begin
				dec.family = ocfd_pkg::FAM_EXT_RC; // see [RULE11]
			end
			4'h7: begin
				dec.family = ocfd_pkg::FAM_STD_XTAL; // see [RULE12]
				dec.pll_mult = ocfd_pkg::PLL_X16;
			end
			4'h6: begin
				dec.family = ocfd_pkg::FAM_STD_XTAL; // see [RULE12]
				dec.pll_mult = ocfd_pkg::PLL_X8;
			end
			4'h5: begin
				dec.family = ocfd_pkg::FAM_STD_XTAL; // see [RULE12]
				dec.pll_mult = ocfd_pkg::PLL_X4;
			end
			4'h4: begin
				dec.family = ocfd_pkg::FAM_STD_XTAL; // see [RULE12]
			end
			4'h3, 4'h2: begin
				dec.family = ocfd_pkg::FAM_HS_XTAL; // see [RULE13]
			end
			default: begin
				// 1010 and the unlisted low codes have no defined mode
				dec.family = ocfd_pkg::FAM_RESERVED; // see [RULE10]
				dec.mode_reserved = 1'b1;
			end
		endcase
		dec.wdt_en = fuse_mem[ocfd_pkg::ADDR_WDT_WORD[2:0]]
			[ocfd_pkg::WDT_EN_BIT]; // see [RULE2]
		dec.code_protect = ~fuse_mem[ocfd_pkg::ADDR_PROT_WORD[2:0]]
			[ocfd_pkg::PROT_BIT];
	end

	// ----------------------------------------------------------------
	// next state: capture, erase tracking, read data
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// one capture after reset, then frozen until the next reset
		if (!st_r.captured) begin
			st_nxt.act = dec; // see [RULE15]
			st_nxt.captured = 1'b1;
		end
		// words erased but not yet rewritten
		if (bus_req.wr && word_hit) begin
			st_nxt.erase_pend[bus_req.addr[2:0]] = 1'b0; // see [RULE4]
		end else if (bus_req.wr && bus_req.addr == ocfd_pkg::ADDR_ERASE
				&& bus_req.wdata[ocfd_pkg::ERASE_GO_BIT]
				&& erase_idx < 3'(ocfd_pkg::NUM_WORDS)) begin
			st_nxt.erase_pend[erase_idx] = 1'b1;
		end
		// read data stand only in the cycle after the strobe
		st_nxt.rdata = ocfd_pkg::READ_UNMAPPED;
		if (bus_req.rd) begin
			if (word_hit) begin
				st_nxt.rdata = fuse_mem[bus_req.addr[2:0]];
			end else if (bus_req.addr == ocfd_pkg::ADDR_STATUS) begin
				st_nxt.rdata = {st_r.captured, 8'h00, st_r.erase_pend};
			end else if (bus_req.addr == ocfd_pkg::ADDR_ACTIVE) begin
				st_nxt.rdata = {2'h0, st_r.act.prim_mode,
					st_r.act.startup_src, st_r.act.pll_mult,
					st_r.act.clk_switch_en, st_r.act.fail_safe_en,
					st_r.act.osc_pin_clkout, st_r.act.mode_reserved,
					st_r.act.wdt_en, st_r.act.code_protect};
			end else begin
				st_nxt.rdata = ocfd_pkg::READ_UNMAPPED;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			st_r <= '{act: ocfd_pkg::SETTINGS_RESET, captured: 1'b0,
				erase_pend: 7'h00, rdata: 16'h0000};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign settings = st_r.act;
	assign settings_valid = st_r.captured;
	assign bus_rdata = st_r.rdata;

	// protection gates both directions of program memory access
	assign pm_rd_grant = pm_req.rd_req & st_r.captured
		& ~st_r.act.code_protect; // see [RULE3]
	assign pm_wr_grant = pm_req.wr_req & st_r.captured
		& ~st_r.act.code_protect; // see [RULE3]

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	a_write_readback: assert property ( // see [RULE1]
		bus_req.wr && bus_req.addr == ocfd_pkg::ADDR_OSC_WORD
		##1 bus_req.rd && bus_req.addr == ocfd_pkg::ADDR_OSC_WORD
		&& !bus_req.wr
		|=> bus_rdata == $past(bus_req.wdata, 2))
		else $error("fuse word did not read back as written");

	a_protect_blocks: assert property ( // see [RULE3]
		settings.code_protect |-> !pm_rd_grant && !pm_wr_grant)
		else $error("program memory reached while protected");

	a_csm_decode: assert property ( // see [RULE6]
		settings_valid |-> settings.fail_safe_en
		== (settings.clk_switch_en && !settings.fail_safe_en ? 1'b0
		: settings.fail_safe_en) && (settings.fail_safe_en
		-> settings.clk_switch_en))
		else $error("monitor enabled without clock switching");

	a_capture_once: assert property ( // see [RULE15]
		$rose(settings_valid) |=> $stable(settings) [*8])
		else $error("settings moved after capture");

	a_capture_time: assert property ( // see [RULE15]
		!settings_valid |=> settings_valid && settings.startup_src
		== $past(osc_w[ocfd_pkg::SRC_LSB +: 2]))
		else $error("startup source not captured one cycle on");

	a_ext_pll: assert property ( // see [RULE8]
		settings_valid && settings.prim_mode == 4'hF |->
		settings.pll_mult == ocfd_pkg::PLL_X16
		&& !settings.osc_pin_clkout)
		else $error("code 1111 not external clock x16");

	a_clkout_codes: assert property ( // see [RULE9]
		settings_valid |-> settings.osc_pin_clkout
		== (settings.prim_mode == 4'hB || settings.prim_mode == 4'h9))
		else $error("clock output pin wrong for mode");

	a_rc_family: assert property ( // see [RULE11]
		settings_valid && settings.prim_mode[3:1] == 3'h4 |->
		settings.family == ocfd_pkg::FAM_EXT_RC)
		else $error("rc codes not decoded as rc");

	a_xtal_pll: assert property ( // see [RULE12]
		settings_valid && settings.prim_mode == 4'h4 |->
		settings.family == ocfd_pkg::FAM_STD_XTAL
		&& settings.pll_mult == ocfd_pkg::PLL_NONE)
		else $error("code 0100 not plain crystal");

	a_hs_family: assert property ( // see [RULE13]
		settings_valid && settings.prim_mode[3:1] == 3'h1 |->
		settings.family == ocfd_pkg::FAM_HS_XTAL)
		else $error("001x not high speed crystal");

	a_ext_x8: assert property ( // see [RULE14]
		settings_valid && settings.prim_mode == 4'hE |->
		settings.pll_mult == ocfd_pkg::PLL_X8)
		else $error("code 1110 not x8");

	a_erase_pending: assert property ( // see [RULE4]
		bus_req.wr && bus_req.addr == ocfd_pkg::ADDR_ERASE
		&& bus_req.wdata == 16'h8000 |=> st_r.erase_pend[0])
		else $error("erase of word 0 not flagged");

	c_capture: cover property ($rose(settings_valid));
	c_protected: cover property (settings.code_protect && pm_req.rd_req);
	c_erase_rewrite: cover property (st_r.erase_pend[0]
		##[1:20] !st_r.erase_pend[0]);
	c_reserved: cover property (settings.mode_reserved);

endmodule : ocfd_top

`default_nettype wire

/* verification/ocfd_prog_model.sv */
// device programmer model driving the fuse register port
`timescale 1ns/100ps
`default_nettype none

module ocfd_prog_model (
	input wire logic ref_clk, // system clock
	input wire logic [15:0] bus_rdata, // read data from the device
	output var ocfd_pkg::ocfd_bus_req_t bus_req // register requests
);
	// ----------------------------------------------------------------
	// bus cycles, changed only by nba right after a rising edge
	// ----------------------------------------------------------------
	initial bus_req = '0;

	// one write cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req <= '0;
	endtask : wr

	// one read cycle, data taken in the single cycle it stands
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req <= '0;
		#1;
		d = bus_rdata;
	endtask : rd

	// oscillator word in this variant's layout; reserved mode refused
	task automatic wr_osc(input logic [1:0] csm, input logic [1:0] src,
		input logic [3:0] pri);
		if (pri != 4'hA) begin
			wr(ocfd_pkg::ADDR_OSC_WORD, {csm, 4'hF, src, 4'hF, pri});
		end
	endtask : wr_osc

	// erase a word, look at it, then always write the wanted value
	task automatic erase_rw(input logic [3:0] idx, input logic [15:0] v,
		output logic [15:0] st, output logic [15:0] w);
		wr(ocfd_pkg::ADDR_ERASE, 16'h8000 | {12'h000, idx});
		rd(idx, w);
		rd(ocfd_pkg::ADDR_STATUS, st);
		wr(idx, v);
	endtask : erase_rw
endmodule : ocfd_prog_model
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench for the configuration fuse decoder
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	logic ref_clk;
	logic reset;
	ocfd_pkg::ocfd_bus_req_t bus_req;
	ocfd_pkg::ocfd_pm_req_t pm_req;
	logic [15:0] bus_rdata;
	logic pm_rd_grant;
	logic pm_wr_grant;
	ocfd_pkg::ocfd_settings_t settings;
	logic settings_valid;
	int n_mismatch = 0;
	int checks_done = 0;

	// ----------------------------------------------------------------
	// clock, design and programmer
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	ocfd_top dut (.ref_clk(ref_clk), .reset(reset), .bus_req(bus_req),
		.bus_rdata(bus_rdata), .pm_req(pm_req), .pm_rd_grant(pm_rd_grant),
		.pm_wr_grant(pm_wr_grant), .settings(settings),
		.settings_valid(settings_valid));

	ocfd_prog_model prog (.ref_clk(ref_clk), .bus_rdata(bus_rdata),
		.bus_req(bus_req));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_set(input ocfd_pkg::ocfd_settings_t got,
		input ocfd_pkg::ocfd_settings_t exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk_set

	// expected settings from the three fuse words
	function automatic ocfd_pkg::ocfd_settings_t exp_set(
		input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w6);
		ocfd_pkg::ocfd_settings_t s;
		s = '0;
		s.clk_switch_en = !w0[15];
		s.fail_safe_en = (w0[15:14] == 2'h0);
		s.startup_src = w0[9:8];
		s.prim_mode = w0[3:0];
		s.wdt_en = w1[15];
		s.code_protect = !w6[0];
		casez (w0[3:0])
			4'b11??: s.pll_mult = w0[1:0];
			4'b1011: s.osc_pin_clkout = 1'b1;
			4'b100?: begin
				s.family = ocfd_pkg::FAM_EXT_RC;
				s.osc_pin_clkout = w0[0];
			end
			4'b01??: begin
				s.family = ocfd_pkg::FAM_STD_XTAL;
				s.pll_mult = w0[1:0];
			end
			4'b001?: s.family = ocfd_pkg::FAM_HS_XTAL;
			default: begin
				s.family = ocfd_pkg::FAM_RESERVED;
				s.mode_reserved = 1'b1;
			end
		endcase
		return s;
	endfunction : exp_set

	task automatic do_reset(input int n);
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (n) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask : do_reset

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, erased words read back, erased image decoded
	task automatic t_start;
		logic [15:0] d;
		repeat (9) @(posedge ref_clk);
		#1;
		chk_set(settings, ocfd_pkg::SETTINGS_RESET);
		chk_word({15'h0, settings_valid}, 16'h0000);
		@(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		chk_set(settings, exp_set(16'hFFFF, 16'hFFFF, 16'hFFFF));
		for (int i = 0; i < 7; i++) begin
			prog.rd(i[3:0], d);
			chk_word(d, ocfd_pkg::FUSE_ERASED);
		end
	endtask : t_start

	// primary modes 0010 to 1111 except 1010, every switch mode and source, one reset each
	task automatic t_decode;
		logic [15:0] w0;
		logic [15:0] w1;
		for (int i = 2; i < 16; i++) begin
			if (i == 10)
				continue;
			w0 = {i[1:0], 4'hF, i[3:2], 4'hF, i[3:0]};
			w1 = {i[0], 15'h7FFF};
			prog.wr_osc(i[1:0], i[3:2], i[3:0]);
			prog.wr(ocfd_pkg::ADDR_WDT_WORD, w1);
			do_reset(2);
			chk_set(settings, exp_set(w0, w1, 16'hFFFF));
		end
	endtask : t_decode

	// protection blocks program memory grants
	task automatic t_protect;
		prog.wr(ocfd_pkg::ADDR_PROT_WORD, 16'hFFFE);
		do_reset(2);
		pm_req <= '{rd_req: 1'b1, wr_req: 1'b1};
		@(posedge ref_clk);
		#1;
		chk_word({14'h0, pm_wr_grant, pm_rd_grant}, 16'h0000);
		prog.wr(ocfd_pkg::ADDR_PROT_WORD, 16'hFFFF);
		do_reset(1);
		chk_word({14'h0, pm_wr_grant, pm_rd_grant}, 16'h0003);
		@(posedge ref_clk);
		pm_req <= '{rd_req: 1'b1, wr_req: 1'b0};
		#1;
		chk_word({14'h0, pm_wr_grant, pm_rd_grant}, 16'h0001);
	endtask : t_protect

	// settings hold across a write until the next reset
	task automatic t_hold;
		logic [15:0] d;
		prog.wr_osc(2'h0, 2'h1, 4'h4);
		prog.rd(ocfd_pkg::ADDR_OSC_WORD, d);
		chk_word(d, 16'h3DF4);
		@(posedge ref_clk);
		#1;
		chk_word(bus_rdata, 16'h0000);
		chk_set(settings, exp_set(16'hFFFF, 16'hFFFF, 16'hFFFF));
		do_reset(1);
		chk_set(settings, exp_set(16'h3DF4, 16'hFFFF, 16'hFFFF));
	endtask : t_hold

	// erase then rewrite, status tracking, unmapped index
	task automatic t_erase;
		logic [15:0] st;
		logic [15:0] w;
		prog.erase_rw(4'h1, 16'h7FFF, st, w);
		chk_word(w, ocfd_pkg::FUSE_ERASED);
		chk_word({14'h0, st[15], st[1]}, 16'h0003);
		prog.rd(ocfd_pkg::ADDR_STATUS, st);
		chk_word({15'h0, st[1]}, 16'h0000);
		prog.rd(4'h1, w);
		chk_word(w, 16'h7FFF);
		prog.wr(4'hC, 16'h1234);
		prog.rd(4'hC, w);
		chk_word(w, ocfd_pkg::READ_UNMAPPED);
	endtask : t_erase

	// ----------------------------------------------------------------
	// main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		reset = 1'b1;
		pm_req = '0;
		t_start();
		t_decode();
		t_protect();
		t_hold();
		t_erase();
		give_verdict();
	end

	initial begin
		#(25 * 5000);
		n_mismatch++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
